// ==== rtl/slc_strap_latch.sv ====
// Strap capture block: filters the straps, latches them at reset release, decodes them
// and serves them over AXI4-Lite.
// Assumes the pad ring resolves straps to levels or level codes.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
module slc_strap_latch
   import slc_pkg::*;
(
   input  wire logic                   aclk,                     // 200 MHz clock
   input  wire logic                   aresetn,                  // Power-on reset, active low
   input  wire logic                   ext_reset_n,              // External reset pin, active low
   input  wire logic [PORT_COUNT-1:0]  port_plus_disable_strap,  // Plus-line disable straps
   input  wire logic [PORT_COUNT-1:0]  port_minus_disable_strap, // Minus-line disable straps
   input  wire logic [LEVEL_WIDTH-1:0] fixed_port_count_strap,   // Non-removable level code
   input  wire logic [LEVEL_WIDTH-1:0] charge_port_count_strap,  // Charging level code
   input  wire logic [MODE_WIDTH-1:0]  device_mode_strap,        // Device mode straps
   output logic      [PORT_COUNT-1:0]  port_disable,             // Port disabled, high-speed path
   output logic      [PORT_COUNT-1:0]  ss_port_disable,          // Companion fast path disabled
   output logic      [PORT_COUNT-1:0]  fixed_port_mask,          // Non-removable ports
   output logic      [PORT_COUNT-1:0]  charge_port_mask,         // Charging-detect ports
   output logic      [MODE_WIDTH-1:0]  device_mode,              // Operating mode
   output logic                        config_valid,             // Straps captured
   output logic                        pin_release,              // Pins free for other function
   input  wire logic [3:0]             s_axi_awaddr,             // Write address
   input  wire logic                   s_axi_awvalid,            // Write address valid
   output logic                        s_axi_awready,            // Write address ready
   input  wire logic [31:0]            s_axi_wdata,              // Write data
   input  wire logic [3:0]             s_axi_wstrb,              // Write strobes
   input  wire logic                   s_axi_wvalid,             // Write data valid
   output logic                        s_axi_wready,             // Write data ready
   output logic [1:0]                  s_axi_bresp,              // Write response
   output logic                        s_axi_bvalid,             // Write response valid
   input  wire logic                   s_axi_bready,             // Write response ready
   input  wire logic [3:0]             s_axi_araddr,             // Read address
   input  wire logic                   s_axi_arvalid,            // Read address valid
   output logic                        s_axi_arready,            // Read address ready
   output logic [31:0]                 s_axi_rdata,              // Read data
   output logic [1:0]                  s_axi_rresp,              // Read response
   output logic                        s_axi_rvalid,             // Read data valid
   input  wire logic                   s_axi_rready              // Read data ready
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Level code to thermometer mask; codes above four saturate at all ports
   function automatic logic [PORT_COUNT-1:0] level_to_mask(input logic [LEVEL_WIDTH-1:0] code);
      logic [PORT_COUNT-1:0] m;
      m = '0;
      for (int i = 0; i < PORT_COUNT; i++) begin
         if (code > LEVEL_WIDTH'(i)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic [LEVEL_WIDTH-1:0] clamp_level(input logic [LEVEL_WIDTH-1:0] code);
      return (code > LEVEL_MAX) ? LEVEL_MAX : code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin filter
   logic [SYNC_WIDTH-1:0] pins_raw, pins_flt;
   logic                  ext_rst_flt;
   logic [PORT_COUNT-1:0] plus_flt, minus_flt;
   logic [LEVEL_WIDTH-1:0] fixed_flt, charge_flt;
   logic [MODE_WIDTH-1:0] mode_flt;

   assign pins_raw = {ext_reset_n, device_mode_strap, charge_port_count_strap,
                      fixed_port_count_strap, port_minus_disable_strap, port_plus_disable_strap};

   slc_pin_filter #(
      .WIDTH   (SYNC_WIDTH)
   ) u_filter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (pins_raw),
      .pin_out (pins_flt)
   );

   assign {ext_rst_flt, mode_flt, charge_flt, fixed_flt, minus_flt, plus_flt} = pins_flt;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Capture sequencer and holding flops
   slc_cap_state_t         state_reg, state_next;
   logic [3:0]             settle_reg, settle_next;
   logic [PORT_COUNT-1:0]  plus_reg, plus_next, minus_reg, minus_next;
   logic [LEVEL_WIDTH-1:0] fixed_reg, fixed_next, charge_reg, charge_next;
   logic [MODE_WIDTH-1:0]  mode_reg, mode_next;
   logic                   valid_reg, valid_next;
   logic [7:0]             count_reg, count_next;
   logic                   capture;

   always_comb begin
      state_next  = state_reg;
      settle_next = settle_reg;
      valid_next  = valid_reg;
      capture     = 1'b0;
      case (state_reg)
         CAP_SETTLE: begin
            // Waits out the filter so reset-time zeros are never latched
            if (settle_reg == SETTLE_LAST) begin
               if (ext_rst_flt) begin
                  capture    = 1'b1;
                  state_next = CAP_HOLD;
               end else begin
                  state_next = CAP_EXT_LOW;
               end
            end else begin
               settle_next = settle_reg + 4'h1;
            end
         end
         CAP_HOLD: begin
            if (!ext_rst_flt) begin
               valid_next = 1'b0;
               state_next = CAP_EXT_LOW;
            end
         end
         CAP_EXT_LOW: begin
            if (ext_rst_flt) begin
               capture    = 1'b1;
               state_next = CAP_HOLD;
            end
         end
         default: state_next = CAP_SETTLE;
      endcase
      plus_next   = capture ? plus_flt : plus_reg;
      minus_next  = capture ? minus_flt : minus_reg;
      fixed_next  = capture ? clamp_level(fixed_flt) : fixed_reg;
      charge_next = capture ? clamp_level(charge_flt) : charge_reg;
      mode_next   = capture ? mode_flt : mode_reg;
      count_next  = capture ? count_reg + 8'h01 : count_reg;
      if (capture) begin
         valid_next = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg  <= CAP_SETTLE;
         settle_reg <= '0;
         plus_reg   <= '0;
         minus_reg  <= '0;
         fixed_reg  <= '0;
         charge_reg <= '0;
         mode_reg   <= '0;
         valid_reg  <= 1'b0;
         count_reg  <= '0;
      end else begin
         state_reg  <= state_next;
         settle_reg <= settle_next;
         plus_reg   <= plus_next;
         minus_reg  <= minus_next;
         fixed_reg  <= fixed_next;
         charge_reg <= charge_next;
         mode_reg   <= mode_next;
         valid_reg  <= valid_next;
         count_reg  <= count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Decoded outputs, registered so consumers see clean levels
   logic [PORT_COUNT-1:0] dis_reg, dis_next, fix_m_reg, fix_m_next, chg_m_reg, chg_m_next;
   logic [MODE_WIDTH-1:0] dmode_reg, dmode_next;
   logic                  rel_reg, rel_next;
   logic                  ctl_release_reg, ctl_release_next;

   always_comb begin
      dis_next   = plus_reg & minus_reg;
      fix_m_next = level_to_mask(fixed_reg);
      chg_m_next = level_to_mask(charge_reg);
      dmode_next = mode_reg;
      rel_next   = valid_reg & ctl_release_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dis_reg   <= '0;
         fix_m_reg <= '0;
         chg_m_reg <= '0;
         dmode_reg <= '0;
         rel_reg   <= 1'b0;
      end else begin
         dis_reg   <= dis_next;
         fix_m_reg <= fix_m_next;
         chg_m_reg <= chg_m_next;
         dmode_reg <= dmode_next;
         rel_reg   <= rel_next;
      end
   end

   assign port_disable     = dis_reg;
   assign ss_port_disable  = dis_reg;
   assign fixed_port_mask  = fix_m_reg;
   assign charge_port_mask = chg_m_reg;
   assign device_mode      = dmode_reg;
   assign config_valid     = valid_reg;
   assign pin_release      = rel_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data taken in either order
   logic       aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic [3:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic       bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic       awready_reg, awready_next, wready_reg, wready_next;

   always_comb begin
      aw_held_next     = aw_held_reg;
      w_held_next      = w_held_reg;
      aw_addr_next     = aw_addr_reg;
      w_data_next      = w_data_reg;
      w_strb_next      = w_strb_reg;
      bvalid_next      = bvalid_reg;
      bresp_next       = bresp_reg;
      ctl_release_next = ctl_release_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_held_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_held_next = 1'b1;
         w_data_next = s_axi_wdata;
         w_strb_next = s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      // Commit once both halves are held and no response is pending
      if (aw_held_reg && w_held_reg && !bvalid_reg) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         if (aw_addr_reg == OFS_CONTROL) begin
            bresp_next = RESP_OKAY;
            if (w_strb_reg[0]) begin
               ctl_release_next = w_data_reg[CTL_RELEASE_BIT];
            end
         end else if (aw_addr_reg == OFS_STRAP_RAW || aw_addr_reg == OFS_CONFIG) begin
            bresp_next = RESP_OKAY; // Read-only, write ignored
         end else begin
            bresp_next = RESP_SLVERR;
         end
      end
      awready_next = !aw_held_next;
      wready_next  = !w_held_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg     <= 1'b0;
         w_held_reg      <= 1'b0;
         aw_addr_reg     <= '0;
         w_data_reg      <= '0;
         w_strb_reg      <= '0;
         bvalid_reg      <= 1'b0;
         bresp_reg       <= RESP_OKAY;
         awready_reg     <= 1'b0;
         wready_reg      <= 1'b0;
         ctl_release_reg <= CTL_RELEASE_RESET;
      end else begin
         aw_held_reg     <= aw_held_next;
         w_held_reg      <= w_held_next;
         aw_addr_reg     <= aw_addr_next;
         w_data_reg      <= w_data_next;
         w_strb_reg      <= w_strb_next;
         bvalid_reg      <= bvalid_next;
         bresp_reg       <= bresp_next;
         awready_reg     <= awready_next;
         wready_reg      <= wready_next;
         ctl_release_reg <= ctl_release_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel: one read at a time, answer one cycle after acceptance
   logic        arready_reg, arready_next, rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;

   always_comb begin
      arready_next = arready_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      if (arready_reg && s_axi_arvalid) begin
         arready_next = 1'b0;
         rvalid_next  = 1'b1;
         rdata_next   = '0;
         rresp_next   = RESP_OKAY;
         if (s_axi_araddr == OFS_STRAP_RAW) begin
            rdata_next[RAW_PLUS_LSB +: PORT_COUNT]    = plus_reg;
            rdata_next[RAW_MINUS_LSB +: PORT_COUNT]   = minus_reg;
            rdata_next[RAW_FIXED_LSB +: LEVEL_WIDTH]  = fixed_reg;
            rdata_next[RAW_CHARGE_LSB +: LEVEL_WIDTH] = charge_reg;
            rdata_next[RAW_MODE_LSB +: MODE_WIDTH]    = mode_reg;
         end else if (s_axi_araddr == OFS_CONFIG) begin
            rdata_next[CFG_DIS_LSB +: PORT_COUNT]    = dis_reg;
            rdata_next[CFG_FIXED_LSB +: PORT_COUNT]  = fix_m_reg;
            rdata_next[CFG_CHARGE_LSB +: PORT_COUNT] = chg_m_reg;
            rdata_next[CFG_MODE_LSB +: MODE_WIDTH]   = dmode_reg;
            rdata_next[CFG_VALID_BIT]                = valid_reg;
            rdata_next[CFG_COUNT_LSB +: 8]           = count_reg;
         end else if (s_axi_araddr == OFS_CONTROL) begin
            rdata_next[CTL_RELEASE_BIT] = ctl_release_reg;
         end else begin
            rresp_next = RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next  = 1'b0;
         arready_next = 1'b1;
      end else if (!rvalid_reg) begin
         arready_next = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end else begin
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

endmodule // slc_strap_latch

// ==== rtl/slc_pkg.sv ====
// Constants and types shared by the strap capture block.
// Assumes a single 200 MHz clock domain and AXI4-Lite register access.
package slc_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int PORT_COUNT   = 4;
   localparam int LEVEL_WIDTH  = 3;
   localparam int MODE_WIDTH   = 3;
   localparam int SYNC_WIDTH   = 18;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [3:0] OFS_STRAP_RAW = 4'h0;
   localparam logic [3:0] OFS_CONFIG    = 4'h4;
   localparam logic [3:0] OFS_CONTROL   = 4'h8;

   // Field positions, raw strap register
   localparam int RAW_PLUS_LSB  = 0;
   localparam int RAW_MINUS_LSB = 4;
   localparam int RAW_FIXED_LSB = 8;
   localparam int RAW_CHARGE_LSB = 12;
   localparam int RAW_MODE_LSB  = 16;

   // Field positions, decoded config register
   localparam int CFG_DIS_LSB    = 0;
   localparam int CFG_FIXED_LSB  = 4;
   localparam int CFG_CHARGE_LSB = 8;
   localparam int CFG_MODE_LSB   = 12;
   localparam int CFG_VALID_BIT  = 16;
   localparam int CFG_COUNT_LSB  = 24;

   // Control register
   localparam int CTL_RELEASE_BIT = 0;
   localparam logic CTL_RELEASE_RESET = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Timing: settle wait after reset release covers the three-flop filter
   localparam int  SETTLE_CYCLES   = 6; // 30 ns at 200 MHz
   localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);

   // Highest legal level code of a multi-level strap
   localparam logic [LEVEL_WIDTH-1:0] LEVEL_MAX = 3'h4;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      CAP_SETTLE,
      CAP_HOLD,
      CAP_EXT_LOW
   } slc_cap_state_t;

endpackage : slc_pkg

// ==== rtl/slc_pin_filter.sv ====
// Three-flop input filter for pins arriving from outside the clock domain.
// Assumes asynchronous inputs; a bit moves once flops two and three agree.
module slc_pin_filter
   import slc_pkg::*;
#(
   parameter int WIDTH = SYNC_WIDTH
) (
   input  wire logic             aclk,      // System clock
   input  wire logic             aresetn,   // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] pin_in,    // Raw pin levels
   output logic      [WIDTH-1:0] pin_out    // Filtered levels
);

   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [WIDTH-1:0] out_next;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Accept a bit only when stages two and three agree
   always_comb begin
      out_next = out_reg;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            out_next[i] = s3_reg[i];
         end
      end
   end

   // First stage feeds only the second, to keep metastability contained
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         out_reg <= '0;
      end else begin
         s1_reg  <= pin_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign pin_out = out_reg;

endmodule // slc_pin_filter

// ==== tb/slc_strap_latch_asserts.sv ====
// Checker of the strap block's ports.
// Assumes one clock, synchronous active-low reset.
module slc_strap_latch_asserts
   import slc_pkg::*;
(
   input wire logic                   aclk,                     // Clock
   input wire logic                   aresetn,                  // Reset, active low
   input wire logic                   ext_reset_n,              // External reset pin
   input wire logic [PORT_COUNT-1:0]  port_plus_disable_strap,  // Plus straps
   input wire logic [PORT_COUNT-1:0]  port_minus_disable_strap, // Minus straps
   input wire logic [LEVEL_WIDTH-1:0] fixed_port_count_strap,   // Fixed code
   input wire logic [LEVEL_WIDTH-1:0] charge_port_count_strap,  // Charge code
   input wire logic [MODE_WIDTH-1:0]  device_mode_strap,        // Mode straps
   input wire logic [PORT_COUNT-1:0]  port_disable,             // Port disabled
   input wire logic [PORT_COUNT-1:0]  ss_port_disable,          // Fast path disabled
   input wire logic [PORT_COUNT-1:0]  fixed_port_mask,          // Fixed ports
   input wire logic [PORT_COUNT-1:0]  charge_port_mask,         // Charging ports
   input wire logic [MODE_WIDTH-1:0]  device_mode,              // Mode
   input wire logic                   config_valid,             // Captured
   input wire logic                   pin_release               // Pins released
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Clamped level code to mask
   function automatic logic [3:0] thermo(input logic [2:0] c);
      return 4'((5'h01 << ((c > 3'h4) ? 3'h4 : c)) - 5'h01);
   endfunction

   // Pins still hold straps one edge after this
   sequence capture_s;
      $rose(config_valid);
   endsequence
   sequence ext_release_s;
      $rose(ext_reset_n) ##1 ext_reset_n [*8];
   endsequence

   chk_ss_mirror:
      assert property (ss_port_disable == port_disable) else $error("fast path disable differs");
   chk_disable_pair:
      assert property (capture_s |=> port_disable == (port_plus_disable_strap & port_minus_disable_strap))
         else $error("port disable decode wrong");
   chk_fixed_count:
      assert property (capture_s |=> fixed_port_mask == thermo(fixed_port_count_strap))
         else $error("fixed port mask wrong");
   chk_charge_count:
      assert property (capture_s |=> charge_port_mask == thermo(charge_port_count_strap))
         else $error("charge port mask wrong");
   chk_mode_capture:
      assert property (capture_s |=> device_mode == device_mode_strap) else $error("mode capture wrong");
   chk_ext_held_low:
      assert property (!ext_reset_n [*8] |-> !config_valid) else $error("valid during external reset");
   chk_ext_recapture:
      assert property (ext_release_s |-> config_valid) else $error("no capture after external reset");
   chk_config_hold:
      assert property (config_valid && $past(config_valid) |=>
         $stable({port_disable, fixed_port_mask, charge_port_mask, device_mode})) else $error("held value moved");
   chk_release_gate:
      assert property (!config_valid |=> !pin_release) else $error("pins released before capture");
endmodule // slc_strap_latch_asserts

bind slc_strap_latch slc_strap_latch_asserts u_chk (.aclk, .aresetn, .ext_reset_n, .port_plus_disable_strap,
   .port_minus_disable_strap, .fixed_port_count_strap, .charge_port_count_strap, .device_mode_strap,
   .port_disable, .ss_port_disable, .fixed_port_mask, .charge_port_mask, .device_mode, .config_valid, .pin_release);

// ==== tb/slc_board_model.sv ====
// Board side: strap resistors on shared pins and the reset source.
// Assumes the bench sets levels and requests reset.
module slc_board_model
   import slc_pkg::*;
(
   input wire logic  aclk,                     // Clock
   input wire logic  hold_reset,               // Bench asks for reset
   input wire logic  pin_release,              // Pins free for traffic
   input wire logic  [3:0] plus_set,           // Wanted plus straps
   input wire logic  [3:0] minus_set,          // Wanted minus straps
   input wire logic  [2:0] fixed_set,          // Wanted fixed code
   input wire logic  [2:0] charge_set,         // Wanted charge code
   input wire logic  [2:0] mode_set,           // Wanted mode
   output logic      ext_reset_n,              // Reset pin
   output logic      [3:0] port_plus_disable_strap,  // Plus pins
   output logic      [3:0] port_minus_disable_strap, // Minus pins
   output logic      [2:0] fixed_port_count_strap,   // Fixed pin
   output logic      [2:0] charge_port_count_strap,  // Charge pin
   output logic      [2:0] device_mode_strap         // Mode pins
);
   logic [16:0] pins_reg = '0;

   // settled straps until pin_release, then toggling traffic; charge resistor fitted, firmware is internal
   always_ff @(posedge aclk) begin
      pins_reg <= pin_release ? ~pins_reg : {plus_set, minus_set, fixed_set, charge_set, mode_set};
   end
   assign ext_reset_n = ~hold_reset;
   assign {port_plus_disable_strap, port_minus_disable_strap, fixed_port_count_strap, charge_port_count_strap,
           device_mode_strap} = pins_reg;
endmodule // slc_board_model

// ==== tb/slc_strap_latch_tb.sv ====
// Bench of the strap block with a board model on the pins.
// Assumes 200 MHz and AXI4-Lite registers.
module slc_strap_latch_tb
   import slc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0, hold_reset = 1'b0, ext_reset_n, config_valid, pin_release;
   logic [3:0]  plus_set = 4'hc, minus_set = 4'h6, port_plus_disable_strap, port_minus_disable_strap;
   logic [3:0]  port_disable, ss_port_disable, fixed_port_mask, charge_port_mask;
   logic [2:0]  fixed_set = 3'h2, charge_set = 3'h1, mode_set = 3'h5, device_mode;
   logic [2:0]  fixed_port_count_strap, charge_port_count_strap, device_mode_strap;
   logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   int          bad_count = 0, comparisons = 0, count_exp = 1;
   // Capture table: one strap alone, all, mixed, clamped codes
   logic [3:0]  tp[6] = '{4'h3, 4'hf, 4'ha, 4'h0, 4'h5, 4'h8};
   logic [3:0]  tm[6] = '{4'h5, 4'hf, 4'ha, 4'hf, 4'h4, 4'h8};
   logic [2:0]  tf[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
   logic [2:0]  tc[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h7};
   logic [2:0]  td[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3};

   slc_strap_latch uut (.aclk, .aresetn, .ext_reset_n, .port_plus_disable_strap, .port_minus_disable_strap,
      .fixed_port_count_strap, .charge_port_count_strap, .device_mode_strap, .port_disable, .ss_port_disable,
      .fixed_port_mask, .charge_port_mask, .device_mode, .config_valid, .pin_release, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   slc_board_model board (.aclk, .hold_reset, .pin_release, .plus_set, .minus_set, .fixed_set, .charge_set,
      .mode_set, .ext_reset_n, .port_plus_disable_strap, .port_minus_disable_strap, .fixed_port_count_strap,
      .charge_port_count_strap, .device_mode_strap);

   always #2.5 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [3:0] thermo(input logic [2:0] c);
      return 4'((5'h01 << ((c > 3'h4) ? 3'h4 : c)) - 5'h01);
   endfunction
   // Master holds each channel until its own handshake edge
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp; s_axi_bready <= 0; break;
         end
      end
   endtask
   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; break;
         end
      end
   endtask
   task automatic wait_valid();
      for (int n = 0; n < 40 && config_valid !== 1'b1; n++) @(posedge aclk);
      repeat (2) @(posedge aclk);
   endtask
   // Outputs and register words against the last straps
   task automatic check_outputs(input logic v);
      check(32'(port_disable), 32'(plus_set & minus_set));
      check(32'(ss_port_disable), 32'(plus_set & minus_set));
      check(32'(fixed_port_mask), 32'(thermo(fixed_set)));
      check(32'(charge_port_mask), 32'(thermo(charge_set)));
      check(32'(device_mode), 32'(mode_set));
      axi_read(4'h4, rd, rr);
      check({rd[31:24], rd[16], rr}, {8'(count_exp), v, RESP_OKAY});
      axi_read(4'h0, rd, rr);
      check({rd[18:16], rd[7:0]}, {mode_set, minus_set, plus_set});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenario: external reset held, old values kept, new straps latched on release
   task automatic recapture(input int i);
      hold_reset <= 1'b1;
      repeat (12) @(posedge aclk);
      check(32'(config_valid), 32'h0);
      check_outputs(1'b0);
      plus_set <= tp[i]; minus_set <= tm[i]; fixed_set <= tf[i]; charge_set <= tc[i]; mode_set <= td[i];
      repeat (6) @(posedge aclk);
      hold_reset <= 1'b0;
      count_exp++;
      wait_valid();
      check_outputs(1'b1);
   endtask
   // Scenario: pins toggle after release, values hold; release gated by control
   task automatic release_and_map();
      repeat (20) @(posedge aclk);
      check(32'(pin_release), 32'h1);
      check_outputs(1'b1);
      axi_write(4'h8, 32'h0, rr);
      repeat (2) @(posedge aclk);
      check(32'(pin_release), 32'h0);
      axi_read(4'hc, rd, rr);
      check(rd, 32'h0);
      check(32'(rr), 32'(RESP_SLVERR));
      axi_write(4'h8, 32'h1, rr);
      check(32'(rr), 32'(RESP_OKAY));
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      wait_valid();
      check_outputs(1'b1);
      for (int i = 0; i < 6; i++) recapture(i);
      release_and_map();
      end_of_test();
   end
   // Watchdog far past the run's length
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      end_of_test();
   end
endmodule // slc_strap_latch_tb
